// [rtl/ufs_pkg.sv]
// Constants, layouts and types of the frame-sync UART
//--------------------------------------------------------------
// Notes on behaviour
// - Synchronous mode: shift clock leaves on output pin, input pin carries data.
// - Synchronous mode is clock master, 8-bit words; software clears inversion/address.
// - Synchronous bit rate is transfer clock divided by twelve, divider ignored.
// - Synchronous transmit: write data shifts out with clock, then completion flag.
// - Synchronous receive: clock generated, line sampled, flag set when word held.
// - Synchronous receive restarts once the reception flag is clear and no transmit is busy or pending.
// - Frame opens with one start bit, found by falling edge or level.
// - Word is eight bits without parity, nine with any parity option.
// - Parity field: 00 none, 01 custom, 10 even, 11 odd.
// - Custom parity bit comes from transmit bit 8, lands in receive bit 8.
// - Odd parity makes the count of ones odd.
// - Even parity makes the count of ones even.
// - Stop period is one, one and a half or two bit times.
// - Data travels least significant bit first.
// - One baud generator setting serves both directions.
// - Oversampling 00: bit time is sixteen times integer plus fraction.
// - Integer divider is 16 bits, 1 to 65535; zero not permitted.
// - Fraction divider is 4 bits, sixteenths of a bit in 16x mode.
// - Transceiver paced by bus clock or either low-speed oscillator, by select.
// - Reception runs on in deep sleep; completion may wake the processor.
// - Flow control pins take part only when flow control is enabled.
// - Oversampling 01: bit time is eight times integer divider.
// - Oversampling 10: bit time is four times integer divider.
// - Oversampling 11: bit rate is 256 times transfer clock over divider.
//--------------------------------------------------------------
package ufs_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_BAUD_INTEGER_DIVIDER = 8'h04;
	localparam logic [7:0] OFS_BAUD_FRACTION_DIVIDER = 8'h08;
	localparam logic [7:0] OFS_TDR = 8'h0C;
	localparam logic [7:0] OFS_RDR = 8'h10;
	localparam logic [7:0] OFS_ISR = 8'h14;

	// Status bit positions
	localparam int ISR_TC = 0;
	localparam int ISR_RC = 1;
	localparam int ISR_BUSY = 2;
	localparam int ISR_PE = 3;
	localparam int ISR_FE = 4;
	localparam int ISR_TXE = 5;

	// Field encodings
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_CUSTOM = 2'h1;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [1:0] PAR_ODD = 2'h3;
	localparam logic [1:0] OVER_16 = 2'h0;
	localparam logic [1:0] OVER_8 = 2'h1;
	localparam logic [1:0] OVER_4 = 2'h2;
	localparam logic [1:0] SRC_BUS = 2'h0;
	localparam logic [1:0] SRC_LSE = 2'h1;

	// Divider figures
	localparam int ACC_W = 24;
	localparam logic [ACC_W-1:0] SYNC_DIV = 24'h00000C;
	localparam logic [ACC_W-1:0] STEP_HALF = 24'h000002;
	localparam logic [ACC_W-1:0] STEP_DED = 24'h000200;
	localparam logic [15:0] BAUD_INTEGER_DIVIDER_RST = 16'h0001;
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam logic [2:0] STOP_HALF_MAX = 3'h4;

	// Configuration word, bit 0 is source[0]
	typedef struct packed {
		logic transmit_enable;
		logic receive_enable;
		logic sync_mode;
		logic [1:0] parity;
		logic [1:0] stop_len;
		logic [1:0] over;
		logic start_level;
		logic flow_enable;
		logic [1:0] source;
	} ufs_cfg_s;
	localparam int CFG_W = 13;

	// Transmit and receive sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_START = 5'b00010,
		ST_DATA = 5'b00100,
		ST_PAR = 5'b01000,
		ST_STOP = 5'b10000
	} ufs_state_e;

endpackage

// [rtl/ufs_uart.sv]
// Frame-sync UART: AHB-Lite registers, baud generator, transmitter, receiver
module ufs_uart (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Oscillator pins used as transfer clock sources
	input wire logic external_low_speed_osc,
	input wire logic internal_low_speed_osc,
	// Serial pins
	output logic serial_out_pin,
	input wire logic serial_in_pin_i,
	output logic serial_in_pin_o,
	output logic serial_in_pin_oe,
	output logic rts_n,
	input wire logic cts_n,
	// Wake request while reception is pending
	output logic rx_wake
);

	//--------------------------------------------------------------
	// Input synchronisers
	//--------------------------------------------------------------
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [1:0] osc_prev_reg;
	logic rx_prev_reg;
	logic rx_line;
	logic cts_ok;

	// Pins cross in two stages; only the second stage is read
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sync1_reg <= 4'hF;
			sync2_reg <= 4'hF;
			osc_prev_reg <= 2'h0;
			rx_prev_reg <= 1'b1;
		end else if (ce) begin
			sync1_reg <= {cts_n, internal_low_speed_osc, external_low_speed_osc, serial_in_pin_i};
			sync2_reg <= sync1_reg;
			osc_prev_reg <= sync2_reg[2:1];
			rx_prev_reg <= sync2_reg[0];
		end
	end
	assign rx_line = sync2_reg[0];
	assign cts_ok = ~sync2_reg[3];

	//--------------------------------------------------------------
	// Registers
	//--------------------------------------------------------------
	ufs_pkg::ufs_cfg_s cfg_reg;
	logic [15:0] baud_integer_divider_reg;
	logic [3:0] baud_fraction_divider_reg;
	logic [8:0] tdr_reg;
	logic tdr_full_reg;
	logic [8:0] rdr_reg;
	logic tc_reg, rc_reg, pe_reg, fe_reg;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic addr_ok;
	logic tx_load, tx_done, rx_done, rx_perr, rx_ferr, tx_busy, rx_busy;
	logic [8:0] rx_word;

	assign addr_ok = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Write data phase follows the captured address
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (ce) begin
			wr_pend_reg <= addr_ok && hwrite;
			wr_addr_reg <= haddr;
		end
	end

	// Read data captured in the address phase, so no wait states
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			hrdata <= 32'h00000000;
		end else if (ce && addr_ok && !hwrite) begin
			hrdata <= 32'h00000000;
			if (haddr == ufs_pkg::OFS_CFG) begin
				hrdata[ufs_pkg::CFG_W-1:0] <= cfg_reg;
			end else if (haddr == ufs_pkg::OFS_BAUD_INTEGER_DIVIDER) begin
				hrdata[15:0] <= baud_integer_divider_reg;
			end else if (haddr == ufs_pkg::OFS_BAUD_FRACTION_DIVIDER) begin
				hrdata[3:0] <= baud_fraction_divider_reg;
			end else if (haddr == ufs_pkg::OFS_TDR) begin
				hrdata[8:0] <= tdr_reg;
			end else if (haddr == ufs_pkg::OFS_RDR) begin
				hrdata[8:0] <= rdr_reg;
			end else if (haddr == ufs_pkg::OFS_ISR) begin
				hrdata[ufs_pkg::ISR_TC] <= tc_reg;
				hrdata[ufs_pkg::ISR_RC] <= rc_reg;
				hrdata[ufs_pkg::ISR_BUSY] <= tx_busy;
				hrdata[ufs_pkg::ISR_PE] <= pe_reg;
				hrdata[ufs_pkg::ISR_FE] <= fe_reg;
				hrdata[ufs_pkg::ISR_TXE] <= ~tdr_full_reg;
			end
		end
	end

	// Configuration and divider writes
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cfg_reg <= '0;
			baud_integer_divider_reg <= ufs_pkg::BAUD_INTEGER_DIVIDER_RST;
			baud_fraction_divider_reg <= 4'h0;
		end else if (ce && wr_pend_reg) begin
			if (wr_addr_reg == ufs_pkg::OFS_CFG) begin
				cfg_reg <= ufs_pkg::ufs_cfg_s'(hwdata[ufs_pkg::CFG_W-1:0]);
			end else if (wr_addr_reg == ufs_pkg::OFS_BAUD_INTEGER_DIVIDER) begin
				baud_integer_divider_reg <= hwdata[15:0];
			end else if (wr_addr_reg == ufs_pkg::OFS_BAUD_FRACTION_DIVIDER) begin
				baud_fraction_divider_reg <= hwdata[3:0];
			end
		end
	end

	// Transmit holding register; bit 8 feeds custom parity
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tdr_reg <= 9'h000;
			tdr_full_reg <= 1'b0;
		end else if (ce) begin
			if (wr_pend_reg && wr_addr_reg == ufs_pkg::OFS_TDR) begin
				tdr_reg <= hwdata[8:0];
				tdr_full_reg <= 1'b1;
			end else if (tx_load) begin
				tdr_full_reg <= 1'b0;
			end
		end
	end

	// Sticky flags: write one to clear, a hardware set wins the same cycle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tc_reg <= 1'b0;
			rc_reg <= 1'b0;
			pe_reg <= 1'b0;
			fe_reg <= 1'b0;
			rdr_reg <= 9'h000;
		end else if (ce) begin
			if (wr_pend_reg && wr_addr_reg == ufs_pkg::OFS_ISR) begin
				tc_reg <= tc_reg & ~hwdata[ufs_pkg::ISR_TC];
				rc_reg <= rc_reg & ~hwdata[ufs_pkg::ISR_RC];
				pe_reg <= pe_reg & ~hwdata[ufs_pkg::ISR_PE];
				fe_reg <= fe_reg & ~hwdata[ufs_pkg::ISR_FE];
			end
			if (tx_done) begin
				tc_reg <= 1'b1;
			end
			if (rx_done) begin
				rc_reg <= 1'b1;
				rdr_reg <= rx_word;
				pe_reg <= pe_reg | rx_perr;
				fe_reg <= fe_reg | rx_ferr;
			end
		end
	end

	//--------------------------------------------------------------
	// Baud generator
	//--------------------------------------------------------------
	logic tclk_tick;
	logic [ufs_pkg::ACC_W-1:0] period, step;

	// Transfer clock pace: every bus cycle or each oscillator rising edge
	always_comb begin
		if (cfg_reg.source == ufs_pkg::SRC_BUS) begin
			tclk_tick = 1'b1;
		end else if (cfg_reg.source == ufs_pkg::SRC_LSE) begin
			tclk_tick = sync2_reg[1] & ~osc_prev_reg[0];
		end else begin
			tclk_tick = sync2_reg[2] & ~osc_prev_reg[1];
		end
	end

	// Bit time in transfer ticks, half-bit events at a doubled step; mode 11 takes the bare divider with a step of 512
	always_comb begin
		step = ufs_pkg::STEP_HALF;
		if (cfg_reg.sync_mode) begin
			period = ufs_pkg::SYNC_DIV;
		end else if (cfg_reg.over == ufs_pkg::OVER_16) begin
			period = {4'h0, baud_integer_divider_reg, baud_fraction_divider_reg};
		end else if (cfg_reg.over == ufs_pkg::OVER_8) begin
			period = {5'h00, baud_integer_divider_reg, 3'h0};
		end else if (cfg_reg.over == ufs_pkg::OVER_4) begin
			period = {6'h00, baud_integer_divider_reg, 2'h0};
		end else begin
			period = {8'h00, baud_integer_divider_reg};
			step = ufs_pkg::STEP_DED;
		end
	end

	// One accumulator per direction, both from the same period
	function automatic logic [ufs_pkg::ACC_W:0] acc_step(input logic [ufs_pkg::ACC_W-1:0] acc);
		logic [ufs_pkg::ACC_W-1:0] sum;
		sum = acc + step;
		if (period != '0 && sum >= period) begin
			acc_step = {1'b1, sum - period};
		end else begin
			acc_step = {1'b0, sum};
		end
	endfunction

	//--------------------------------------------------------------
	// Transmitter
	//--------------------------------------------------------------
	ufs_pkg::ufs_state_e tx_state_reg;
	logic [ufs_pkg::ACC_W-1:0] tx_acc_reg;
	logic [ufs_pkg::ACC_W:0] tx_nxt;
	logic [2:0] tx_half_reg;
	logic [3:0] tx_bit_reg;
	logic [8:0] tx_shift_reg;
	logic tx_par_reg, tx_line_reg, tx_sck_low_reg, tx_half;
	logic [2:0] stop_halves;

	assign tx_nxt = acc_step(tx_acc_reg);
	assign tx_half = tclk_tick && tx_nxt[ufs_pkg::ACC_W];
	assign tx_busy = (tx_state_reg != ufs_pkg::ST_IDLE);
	// Stop field 00/01/10 gives 2/3/4 half bits
	assign stop_halves = (cfg_reg.stop_len == 2'h3) ? ufs_pkg::STOP_HALF_MAX :
		{1'b0, cfg_reg.stop_len} + 3'h2;
	assign tx_load = ce && !tx_busy && tdr_full_reg && cfg_reg.transmit_enable &&
		!(cfg_reg.sync_mode && rx_busy) &&
		(cfg_reg.sync_mode || !cfg_reg.flow_enable || cts_ok);
	assign tx_done = ce && tx_half && (
		(tx_state_reg == ufs_pkg::ST_STOP && tx_half_reg == stop_halves - 3'h1) ||
		(cfg_reg.sync_mode && tx_state_reg == ufs_pkg::ST_DATA &&
		tx_half_reg[0] && tx_bit_reg == ufs_pkg::DATA_BITS - 4'h1));

	// Frame sequencer in half-bit steps
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_state_reg <= ufs_pkg::ST_IDLE;
			tx_acc_reg <= '0;
			tx_half_reg <= 3'h0;
			tx_bit_reg <= 4'h0;
			tx_shift_reg <= 9'h000;
			tx_par_reg <= 1'b0;
			tx_line_reg <= 1'b1;
			tx_sck_low_reg <= 1'b0;
		end else if (ce) begin
			if (tclk_tick) begin
				tx_acc_reg <= tx_nxt[ufs_pkg::ACC_W-1:0];
			end
			case (tx_state_reg)
				ufs_pkg::ST_IDLE: begin
					tx_line_reg <= 1'b1;
					tx_sck_low_reg <= 1'b0;
					if (tx_load) begin
						tx_acc_reg <= '0;
						tx_half_reg <= 3'h0;
						tx_bit_reg <= 4'h0;
						tx_shift_reg <= tdr_reg;
						if (cfg_reg.parity == ufs_pkg::PAR_CUSTOM) begin
							tx_par_reg <= tdr_reg[8];
						end else begin
							// Even: ones total even; odd: ones total odd
							tx_par_reg <= (^tdr_reg[7:0]) ^ (cfg_reg.parity == ufs_pkg::PAR_ODD);
						end
						if (cfg_reg.sync_mode) begin
							tx_state_reg <= ufs_pkg::ST_DATA;
							tx_line_reg <= tdr_reg[0];
							tx_sck_low_reg <= 1'b1;
						end else begin
							tx_state_reg <= ufs_pkg::ST_START;
							tx_line_reg <= 1'b0;
						end
					end
				end
				ufs_pkg::ST_START: begin
					if (tx_half) begin
						tx_half_reg <= tx_half_reg + 3'h1;
						if (tx_half_reg[0]) begin
							tx_half_reg <= 3'h0;
							tx_state_reg <= ufs_pkg::ST_DATA;
							tx_line_reg <= tx_shift_reg[0];
						end
					end
				end
				ufs_pkg::ST_DATA: begin
					if (tx_half) begin
						tx_half_reg <= {2'h0, ~tx_half_reg[0]};
						if (cfg_reg.sync_mode && !tx_half_reg[0]) begin
							tx_sck_low_reg <= 1'b0;
						end else if (tx_half_reg[0]) begin
							tx_bit_reg <= tx_bit_reg + 4'h1;
							tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
							tx_line_reg <= tx_shift_reg[1];
							tx_sck_low_reg <= cfg_reg.sync_mode;
							if (tx_bit_reg == ufs_pkg::DATA_BITS - 4'h1) begin
								tx_sck_low_reg <= 1'b0;
								if (cfg_reg.sync_mode) begin
									tx_state_reg <= ufs_pkg::ST_IDLE;
								end else if (cfg_reg.parity != ufs_pkg::PAR_NONE) begin
									tx_state_reg <= ufs_pkg::ST_PAR;
									tx_line_reg <= tx_par_reg;
								end else begin
									tx_state_reg <= ufs_pkg::ST_STOP;
									tx_line_reg <= 1'b1;
								end
							end
						end
					end
				end
				ufs_pkg::ST_PAR: begin
					if (tx_half) begin
						tx_half_reg <= {2'h0, ~tx_half_reg[0]};
						if (tx_half_reg[0]) begin
							tx_state_reg <= ufs_pkg::ST_STOP;
							tx_line_reg <= 1'b1;
						end
					end
				end
				default: begin
					if (tx_half) begin
						tx_half_reg <= tx_half_reg + 3'h1;
						if (tx_half_reg == stop_halves - 3'h1) begin
							tx_state_reg <= ufs_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// Receiver
	//--------------------------------------------------------------
	ufs_pkg::ufs_state_e rx_state_reg;
	logic [ufs_pkg::ACC_W-1:0] rx_acc_reg;
	logic [ufs_pkg::ACC_W:0] rx_nxt;
	logic rx_phase_reg, rx_sck_low_reg, rx_half, rx_start, rx_sync_go;
	logic [3:0] rx_bit_reg;
	logic [8:0] rx_shift_reg;

	assign rx_nxt = acc_step(rx_acc_reg);
	assign rx_half = tclk_tick && rx_nxt[ufs_pkg::ACC_W];
	assign rx_busy = (rx_state_reg != ufs_pkg::ST_IDLE);
	// Start by falling edge or by low level, as configured
	assign rx_start = !rx_line && (cfg_reg.start_level || rx_prev_reg);
	// Next synchronous word starts once the flag is clear and no transmit is busy or pending
	assign rx_sync_go = !rc_reg && !tx_busy && !(tdr_full_reg && cfg_reg.transmit_enable);
	assign rx_word = cfg_reg.parity == ufs_pkg::PAR_NONE || cfg_reg.sync_mode ?
		{1'b0, rx_shift_reg[8:1]} : rx_shift_reg;
	assign rx_perr = !cfg_reg.sync_mode && cfg_reg.parity[1] &&
		((^rx_shift_reg) != cfg_reg.parity[0]);
	assign rx_ferr = !cfg_reg.sync_mode && !rx_line;
	assign rx_done = ce && rx_half && rx_phase_reg &&
		(rx_state_reg == ufs_pkg::ST_STOP ||
		(cfg_reg.sync_mode && rx_state_reg == ufs_pkg::ST_DATA &&
		rx_bit_reg == ufs_pkg::DATA_BITS - 4'h1));

	// Samples mid-bit in async mode, on the falling clock edge in sync mode
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rx_state_reg <= ufs_pkg::ST_IDLE;
			rx_acc_reg <= '0;
			rx_phase_reg <= 1'b0;
			rx_sck_low_reg <= 1'b0;
			rx_bit_reg <= 4'h0;
			rx_shift_reg <= 9'h000;
		end else if (ce) begin
			if (tclk_tick) begin
				rx_acc_reg <= rx_nxt[ufs_pkg::ACC_W-1:0];
			end
			case (rx_state_reg)
				ufs_pkg::ST_IDLE: begin
					rx_sck_low_reg <= 1'b0;
					rx_acc_reg <= '0;
					rx_phase_reg <= 1'b0;
					rx_bit_reg <= 4'h0;
					if (cfg_reg.receive_enable && cfg_reg.sync_mode && rx_sync_go) begin
						rx_state_reg <= ufs_pkg::ST_DATA;
						rx_sck_low_reg <= 1'b1;
					end else if (cfg_reg.receive_enable && !cfg_reg.sync_mode && rx_start) begin
						rx_state_reg <= ufs_pkg::ST_START;
					end
				end
				ufs_pkg::ST_START: begin
					if (rx_half) begin
						rx_state_reg <= rx_line ? ufs_pkg::ST_IDLE : ufs_pkg::ST_DATA;
					end
				end
				ufs_pkg::ST_DATA, ufs_pkg::ST_PAR: begin
					if (rx_half) begin
						rx_phase_reg <= ~rx_phase_reg;
						if (!rx_phase_reg) begin
							rx_sck_low_reg <= 1'b0;
						end else begin
							rx_shift_reg <= {rx_line, rx_shift_reg[8:1]};
							rx_bit_reg <= rx_bit_reg + 4'h1;
							rx_sck_low_reg <= cfg_reg.sync_mode;
							if (rx_state_reg == ufs_pkg::ST_PAR) begin
								rx_state_reg <= ufs_pkg::ST_STOP;
							end else if (rx_bit_reg == ufs_pkg::DATA_BITS - 4'h1) begin
								rx_sck_low_reg <= 1'b0;
								if (cfg_reg.sync_mode) begin
									rx_state_reg <= ufs_pkg::ST_IDLE;
								end else if (cfg_reg.parity != ufs_pkg::PAR_NONE) begin
									rx_state_reg <= ufs_pkg::ST_PAR;
								end else begin
									rx_state_reg <= ufs_pkg::ST_STOP;
								end
							end
						end
					end
				end
				default: begin
					if (rx_half) begin
						rx_phase_reg <= ~rx_phase_reg;
						if (rx_phase_reg) begin
							rx_state_reg <= ufs_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// Pin drive
	//--------------------------------------------------------------
	// Sync mode: output pin is the shift clock, input pin carries data
	assign serial_out_pin = cfg_reg.sync_mode ? ~(tx_sck_low_reg | rx_sck_low_reg) :
		tx_line_reg;
	assign serial_in_pin_o = tx_line_reg;
	assign serial_in_pin_oe = cfg_reg.sync_mode && tx_busy;
	assign rts_n = ~(cfg_reg.flow_enable && cfg_reg.receive_enable && !rc_reg);
	assign rx_wake = rc_reg && cfg_reg.receive_enable;

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	AST_SCK_IDLE: assert property (cfg_reg.sync_mode && !tx_busy && !rx_busy |-> serial_out_pin) else $error("shift clock not idle high");
	AST_TC_SET: assert property (tx_done |=> tc_reg) else $error("transmit completion not flagged");
	AST_RC_SET: assert property (rx_done |=> rc_reg && rdr_reg == $past(rx_word)) else $error("receive word not held");
	AST_SYNC_DIV: assert property (cfg_reg.sync_mode |-> period == ufs_pkg::SYNC_DIV) else $error("sync divider wrong");
	AST_START_LOW: assert property (tx_state_reg == ufs_pkg::ST_START |-> !tx_line_reg) else $error("start bit not low");
	AST_STOP_HIGH: assert property (tx_state_reg == ufs_pkg::ST_STOP |-> tx_line_reg) else $error("stop bit not high");
	AST_PAR_EVEN: assert property (tx_state_reg == ufs_pkg::ST_PAR && cfg_reg.parity == ufs_pkg::PAR_EVEN |-> !(^{tx_line_reg, tdr_reg[7:0]}) || tdr_full_reg) else $error("even parity wrong");
	AST_PAR_ODD: assert property (tx_state_reg == ufs_pkg::ST_PAR && cfg_reg.parity == ufs_pkg::PAR_ODD |-> (^{tx_line_reg, tdr_reg[7:0]}) || tdr_full_reg) else $error("odd parity wrong");
	AST_OE_SYNC: assert property (serial_in_pin_oe |-> cfg_reg.sync_mode && $past(tx_busy || tx_load)) else $error("data pin driven outside sync transmit");
	AST_RTS_IDLE: assert property (!cfg_reg.flow_enable |-> rts_n) else $error("request-to-send active without flow control");

endmodule

// [verif/ufs_peer.sv]
// Remote UART model: frame sender and frame catcher
module ufs_peer (
	// Clock and lines
	input wire logic clk_sys,
	input wire logic line_in,
	input wire logic listen,
	output logic line_out,
	// Frame shape in clock cycles and bits
	input wire logic [15:0] bt,
	input wire logic [3:0] nbits
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] got;
	logic stop_ok;
	int n_got = 0;
	// Pull-up keeps the line high between frames
	initial line_out = 1'b1;
	// Catch frames at mid-bit; falling edge opens a frame
	always begin
		@(negedge line_in iff listen);
		got = '0;
		repeat (bt / 2) @(posedge clk_sys);
		for (int i = 0; i < nbits; i++) begin
			repeat (bt) @(posedge clk_sys);
			got[i] = line_in;
		end
		repeat (bt) @(posedge clk_sys);
		stop_ok = line_in;
		n_got++;
	end
	// Send one start bit, data LSB first, then two stop bits
	task automatic send(input logic [8:0] w, input int n);
		@(posedge clk_sys);
		line_out <= 1'b0;
		repeat (bt) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			line_out <= w[i];
			repeat (bt) @(posedge clk_sys);
		end
		line_out <= 1'b1;
		repeat (2 * bt) @(posedge clk_sys);
	endtask
endmodule

// [verif/uart_frame_sync_baud_tb.sv]
// Self-checking bench of the frame-sync UART
module uart_frame_sync_baud_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [7:0] haddr = 8'h00;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, serial_out_pin, pin_o, pin_oe, rts_n, rx_wake, peer_out;
	logic listen = 1'b0;
	logic [15:0] bt = 16'h0023; // 16 * 2 + 3 ticks per bit
	logic [3:0] nbits = 4'h8;
	logic [31:0] seed = 32'h07869A05;
	int n_mismatch = 0;
	int checked = 0;
	ufs_pkg::ufs_cfg_s cfg;
	// Shared data line: device drives only with its enable up
	wire logic line = pin_oe ? pin_o : peer_out;
	ufs_uart u_ufs_uart (.clk_sys(clk_sys), .reset(reset), .ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.external_low_speed_osc(1'b0), .internal_low_speed_osc(1'b0),
		.serial_out_pin(serial_out_pin), .serial_in_pin_i(line), .serial_in_pin_o(pin_o),
		.serial_in_pin_oe(pin_oe), .rts_n(rts_n), .cts_n(1'b0), .rx_wake(rx_wake));
	ufs_peer u_ufs_peer (.clk_sys(clk_sys), .line_in(serial_out_pin), .listen(listen),
		.line_out(peer_out), .bt(bt), .nbits(nbits));
	always #5 clk_sys = ~clk_sys;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Expected ninth bit for each parity setting
	function automatic logic exp9(input logic [8:0] w, input logic [1:0] par);
		case (par)
			ufs_pkg::PAR_CUSTOM: return w[8];
			ufs_pkg::PAR_EVEN: return ^w[7:0];
			ufs_pkg::PAR_ODD: return ~^w[7:0];
			default: return 1'b0;
		endcase
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One single AHB-Lite transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic poll(input int b);
		int k;
		k = 0;
		do begin
			bus(1'b0, ufs_pkg::OFS_ISR, 32'h0);
			k++;
		end while (rd[b] !== 1'b1 && k < 400);
	endtask
	task automatic test_done;
		$display("mismatches %0d comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard, well beyond the longest expected run
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_mismatch++;
		test_done;
	end
	//--------------------------------
	// Main sequence
	//--------------------------------
	initial begin
		logic [8:0] w;
		logic p;
		int n, last;
		logic sck_q;
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		bus(1'b0, ufs_pkg::OFS_BAUD_INTEGER_DIVIDER, 32'h0);
		chk("baud_integer_divider reset", rd, {16'h0, ufs_pkg::BAUD_INTEGER_DIVIDER_RST});
		bus(1'b0, 8'h1C, 32'h0);
		chk("unmapped read", rd, 32'h0);
		bus(1'b1, ufs_pkg::OFS_BAUD_INTEGER_DIVIDER, 32'h2);
		bus(1'b1, ufs_pkg::OFS_BAUD_FRACTION_DIVIDER, 32'h3);
		listen <= 1'b1;
		// Transmit under every parity and stop setting
		for (int m = 0; m < 4; m++) begin
			seed = xs(seed);
			w = seed[8:0];
			cfg = '0;
			cfg.transmit_enable = 1'b1;
			cfg.receive_enable = 1'b1;
			cfg.parity = m[1:0];
			cfg.stop_len = m[1:0];
			nbits <= (m == 0) ? 4'h8 : 4'h9;
			bus(1'b1, ufs_pkg::OFS_CFG, {19'h0, cfg});
			bus(1'b1, ufs_pkg::OFS_TDR, {23'h0, w});
			poll(ufs_pkg::ISR_TC);
			chk("tx data", u_ufs_peer.got[7:0], w[7:0]);
			chk("tx ninth", u_ufs_peer.got[8], exp9(w, cfg.parity));
			chk("tx stop", u_ufs_peer.stop_ok, 1);
			bus(1'b1, ufs_pkg::OFS_ISR, 32'h1);
		end
		// Receive with good then bad even parity
		cfg.parity = ufs_pkg::PAR_EVEN;
		bus(1'b1, ufs_pkg::OFS_CFG, {19'h0, cfg});
		for (int e = 0; e < 2; e++) begin
			seed = xs(seed);
			p = ^seed[7:0] ^ e[0];
			u_ufs_peer.send({p, seed[7:0]}, 9);
			poll(ufs_pkg::ISR_RC);
			chk("rx wake", rx_wake, 1);
			chk("rts unused", rts_n, 1);
			chk("bus okay", hresp, 0);
			bus(1'b0, ufs_pkg::OFS_RDR, 32'h0);
			chk("rx word", rd, {23'h0, p, seed[7:0]});
			bus(1'b0, ufs_pkg::OFS_ISR, 32'h0);
			chk("rx parity error", rd[ufs_pkg::ISR_PE], e[0]);
			bus(1'b1, ufs_pkg::OFS_ISR, 32'h1A);
		end
		// Synchronous transmit: clock on output pin, data on shared line
		cfg = '0;
		cfg.sync_mode = 1'b1;
		cfg.transmit_enable = 1'b1;
		listen <= 1'b0;
		bus(1'b1, ufs_pkg::OFS_CFG, {19'h0, cfg});
		chk("sck idle", serial_out_pin, 1);
		seed = xs(seed);
		bus(1'b1, ufs_pkg::OFS_TDR, {24'h0, seed[7:0]});
		w = '0;
		n = 0;
		last = 0;
		sck_q = 1'b1;
		for (int c = 0; c < 400 && n < 8; c++) begin
			@(posedge clk_sys);
			#1;
			if (serial_out_pin === 1'b1 && sck_q === 1'b0) begin
				w[n] = line;
				chk("data driven", pin_oe, 1);
				if (n > 0)
					chk("sck period", c - last, 12);
				last = c;
				n++;
			end
			sck_q = serial_out_pin;
		end
		chk("sync data", w, {1'b0, seed[7:0]});
		poll(ufs_pkg::ISR_TC);
		chk("sync done", rd[ufs_pkg::ISR_TC], 1);
		test_done;
	end
endmodule
